// *** design/eei_pkg.sv ***
// Constants, types and states shared by the serial EEPROM target
package eei_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CORE_CLK_MHZ                = 100;
  localparam int LINK_CLK_PERIOD_NS          = 12;
  localparam int INPUT_GLITCH_FILTER_TIME_NS = 100;
  localparam int GLITCH_CYCLES               =
    (INPUT_GLITCH_FILTER_TIME_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  localparam int WRITE_CYCLE_TIME_MS         = 5;
  localparam int WRITE_CYCLE_CYCLES          = WRITE_CYCLE_TIME_MS * 1000 * CORE_CLK_MHZ;
  localparam int POWER_UP_READY_DELAY_MS     = 1;
  localparam int POWER_UP_CYCLES             = POWER_UP_READY_DELAY_MS * 1000 * CORE_CLK_MHZ;
  localparam int TMR_W                       = 20;

  // ************************************************************
  // Array layout
  // ************************************************************
  localparam int PAGE_COUNT = 512;
  localparam int PAGE_BYTES = 64;
  localparam int MEM_BYTES  = PAGE_COUNT * PAGE_BYTES;
  localparam int OFF_W      = 6;
  localparam int PTR_W      = 15;
  localparam int FIFO_DEPTH = 16;
  localparam logic [6:0] COPY_END    = 7'h40;
  localparam logic [3:0] GLITCH_LAST = 4'(GLITCH_CYCLES - 1);

  // ************************************************************
  // Bus framing
  // ************************************************************
  // Arbitrary device type code
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [3:0] BIT_END       = 4'h9;

  typedef enum logic [1:0] {
    CMD_SET_ADDR = 2'b00,
    CMD_WRITE    = 2'b01,
    CMD_READ     = 2'b10,
    CMD_STOP     = 2'b11
  } eei_cmd_t;

  typedef struct packed {
    eei_cmd_t    cmd;
    logic [15:0] addr;
    logic [7:0]  data;
  } eei_req_t;

  typedef enum logic [2:0] {
    LS_IDLE    = 3'b000,
    LS_DEV     = 3'b001,
    LS_ADDR_HI = 3'b010,
    LS_ADDR_LO = 3'b011,
    LS_WRITE   = 3'b100,
    LS_READ    = 3'b101
  } eei_link_st_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_READ = 2'b01,
    CS_COPY = 2'b10,
    CS_HOLD = 2'b11
  } eei_core_st_t;

endpackage

// *** design/eei_mem.sv ***
// Byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module eei_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  if (DEPTH != (1 << AW)) begin : g_chk
    $error("eei_mem depth must be two to the address width");
  end

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// *** design/eei_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module eei_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH != (1 << PW)) begin : g_chk
    $error("eei_fifo depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wr_ptr;
  logic [PW:0]  rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[PW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{PW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{PW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// *** design/eei_target.sv ***
// Serial EEPROM bus target: pin logic, page buffer and array control
`timescale 1ns/1ps
`default_nettype none
module eei_target #(
  parameter int WRITE_CYCLES    = eei_pkg::WRITE_CYCLE_CYCLES,
  parameter int POWER_UP_CYCLES = eei_pkg::POWER_UP_CYCLES,
  parameter int FIFO_DEPTH      = eei_pkg::FIFO_DEPTH
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       wp_i,
  input  wire logic [2:0] strap_address_pins_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic            ready_o
);
  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << eei_pkg::TMR_W) ||
      POWER_UP_CYCLES < 1 || POWER_UP_CYCLES >= (1 << eei_pkg::TMR_W)) begin : g_chk
    $error("eei_target timing counts out of range");
  end

  // ************************************************************
  // Link domain: reset and input synchronisers
  // ************************************************************
  logic [1:0]           lrst_sync;
  logic                 link_rst_n;
  logic [6:0]           lin_meta;
  logic [6:0]           lin_s;
  logic [1:0]           filt;
  logic [1:0]           filt_d;
  logic [1:0][3:0]      fcnt;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_ev;
  logic                 stop_ev;
  logic                 ack_s;
  logic                 ready_s;
  logic [2:0]           strap_s;
  eei_pkg::eei_link_st_t lst;
  logic [3:0]           bit_cnt;
  logic [7:0]           shreg;
  logic [7:0]           txreg;
  logic [7:0]           addr_hi;
  logic                 nack;
  logic                 dev_hit;
  logic                 pend;
  logic                 issue;
  logic                 req_tog;
  logic                 ack_tog;
  logic [7:0]           resp_data;
  eei_pkg::eei_req_t    req;
  eei_pkg::eei_req_t    next_req;

  always_ff @(posedge link_clk_i) begin
    lrst_sync <= {lrst_sync[0], rst_n_i};
  end
  assign link_rst_n = lrst_sync[1];

  // Strap pins rely on the pad pull-down when open
  always_ff @(posedge link_clk_i) begin
    lin_meta <= {ack_tog, ready_o, strap_address_pins_i, sda_i, scl_i};
    lin_s    <= lin_meta;
  end
  assign ack_s   = lin_s[6];
  assign ready_s = lin_s[5];
  assign strap_s = lin_s[4:2];

  // ************************************************************
  // Glitch filter and bus events
  // ************************************************************
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n) begin
      filt   <= 2'h3;
      filt_d <= 2'h3;
      fcnt   <= '0;
    end else begin
      filt_d <= filt;
      for (int i = 0; i < 2; i++) begin
        if (lin_s[i] == filt[i]) begin
          fcnt[i] <= 4'h0;
        end else if (fcnt[i] == eei_pkg::GLITCH_LAST) begin
          filt[i] <= lin_s[i];
          fcnt[i] <= 4'h0;
        end else begin
          fcnt[i] <= fcnt[i] + 4'h1;
        end
      end
    end
  end

  // Filter delay is far below the fast-rate bit period
  assign scl_rise = filt[0] & ~filt_d[0];
  assign scl_fall = ~filt[0] & filt_d[0];
  assign start_ev = filt[0] & filt_d[0] & filt_d[1] & ~filt[1];
  assign stop_ev  = filt[0] & filt_d[0] & ~filt_d[1] & filt[1];

  assign dev_hit = (shreg[7:4] == eei_pkg::DEV_TYPE_CODE) & (shreg[3:1] == strap_s) & ready_s;
  assign pend    = req_tog != ack_s;

  // ************************************************************
  // Link state machine
  // ************************************************************
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n) begin
      lst        <= eei_pkg::LS_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      txreg      <= 8'h00;
      addr_hi    <= 8'h00;
      nack       <= 1'b0;
      sda_oe_n_o <= 1'b1;
      sda_o      <= 1'b0;
    end else if (start_ev) begin
      lst        <= eei_pkg::LS_DEV;
      bit_cnt    <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end else if (stop_ev) begin
      lst        <= eei_pkg::LS_IDLE;
      sda_oe_n_o <= 1'b1;
    end else if (lst != eei_pkg::LS_IDLE) begin
      sda_o <= 1'b0;
      if (scl_rise) begin
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt < eei_pkg::BIT_ACK) begin
          shreg <= {shreg[6:0], filt[1]};
        end else if (lst == eei_pkg::LS_READ) begin
          nack <= filt[1];
        end
      end
      if (scl_fall) begin
        if (bit_cnt == eei_pkg::BIT_ACK) begin
          case (lst)
            eei_pkg::LS_DEV: begin
              if (dev_hit) begin
                sda_oe_n_o <= 1'b0;
              end else begin
                lst <= eei_pkg::LS_IDLE;
              end
            end
            eei_pkg::LS_ADDR_HI: begin
              addr_hi    <= shreg;
              sda_oe_n_o <= 1'b0;
            end
            eei_pkg::LS_ADDR_LO,
            eei_pkg::LS_WRITE: begin
              sda_oe_n_o <= 1'b0;
            end
            default: begin
              sda_oe_n_o <= 1'b1;
            end
          endcase
        end else if (bit_cnt == eei_pkg::BIT_END) begin
          bit_cnt <= 4'h0;
          case (lst)
            eei_pkg::LS_DEV: begin
              if (shreg[0]) begin
                lst        <= eei_pkg::LS_READ;
                sda_oe_n_o <= resp_data[7];
                txreg      <= {resp_data[6:0], 1'b0};
              end else begin
                lst        <= eei_pkg::LS_ADDR_HI;
                sda_oe_n_o <= 1'b1;
              end
            end
            eei_pkg::LS_ADDR_HI: begin
              lst        <= eei_pkg::LS_ADDR_LO;
              sda_oe_n_o <= 1'b1;
            end
            eei_pkg::LS_READ: begin
              if (nack) begin
                lst        <= eei_pkg::LS_IDLE;
                sda_oe_n_o <= 1'b1;
              end else begin
                sda_oe_n_o <= resp_data[7];
                txreg      <= {resp_data[6:0], 1'b0};
              end
            end
            default: begin
              lst        <= eei_pkg::LS_WRITE;
              sda_oe_n_o <= 1'b1;
            end
          endcase
        end else if (lst == eei_pkg::LS_READ) begin
          sda_oe_n_o <= txreg[7];
          txreg      <= {txreg[6:0], 1'b0};
        end
      end
    end
  end

  // ************************************************************
  // Requests to the core domain
  // ************************************************************
  always_comb begin
    issue    = 1'b0;
    next_req = req;
    if (stop_ev && (lst == eei_pkg::LS_ADDR_HI || lst == eei_pkg::LS_ADDR_LO || lst == eei_pkg::LS_WRITE)) begin
      issue        = 1'b1;
      next_req.cmd = eei_pkg::CMD_STOP;
    end else if (lst != eei_pkg::LS_IDLE && scl_fall && bit_cnt == eei_pkg::BIT_ACK) begin
      if (lst == eei_pkg::LS_DEV && dev_hit && shreg[0]) begin
        issue        = 1'b1;
        next_req.cmd = eei_pkg::CMD_READ;
      end else if (lst == eei_pkg::LS_ADDR_LO) begin
        issue         = 1'b1;
        next_req.cmd  = eei_pkg::CMD_SET_ADDR;
        next_req.addr = {addr_hi, shreg};
      end else if (lst == eei_pkg::LS_WRITE) begin
        issue         = 1'b1;
        next_req.cmd  = eei_pkg::CMD_WRITE;
        next_req.data = shreg;
      end
    end else if (lst == eei_pkg::LS_READ && scl_rise && bit_cnt == eei_pkg::BIT_ACK && !filt[1]) begin
      issue        = 1'b1;
      next_req.cmd = eei_pkg::CMD_READ;
    end
    issue = issue & ~pend;
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n) begin
      req_tog <= 1'b0;
      req     <= '0;
    end else if (issue) begin
      req_tog <= ~req_tog;
      req     <= next_req;
    end
  end

  // ************************************************************
  // Core domain: synchronisers and power-up
  // ************************************************************
  logic [1:0]            cin_meta;
  logic [1:0]            cin_s;
  logic                  wp_s;
  logic                  req_new;
  logic [eei_pkg::TMR_W-1:0] pu_cnt;
  logic                  powered;
  eei_pkg::eei_core_st_t cst;
  logic [eei_pkg::PTR_W-1:0] ptr;
  logic [eei_pkg::PAGE_BYTES-1:0] marks;
  logic [6:0]            copy_idx;
  logic                  copy_we;
  logic [eei_pkg::OFF_W-1:0] copy_off;
  logic [eei_pkg::TMR_W-1:0] timer;
  logic                  push;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [7:0]            fifo_out_data;
  logic                  load;
  logic                  arr_re;
  logic [7:0]            arr_rdata;
  logic [7:0]            pb_rdata;

  // Write protect relies on the pad pull-down when open
  always_ff @(posedge core_clk_i) begin
    cin_meta <= {wp_i, req_tog};
    cin_s    <= cin_meta;
  end
  assign wp_s    = cin_s[1];
  assign req_new = (cin_s[0] != ack_tog) && (cst == eei_pkg::CS_IDLE);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pu_cnt  <= '0;
      powered <= 1'b0;
    end else if (!powered) begin
      pu_cnt  <= pu_cnt + 20'h00001;
      powered <= pu_cnt == 20'(POWER_UP_CYCLES - 1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= powered && (cst == eei_pkg::CS_IDLE || cst == eei_pkg::CS_READ);
    end
  end

  // ************************************************************
  // Write data buffering
  // ************************************************************
  assign push           = req_new && req.cmd == eei_pkg::CMD_WRITE;
  assign fifo_out_ready = cst == eei_pkg::CS_IDLE;
  assign load           = fifo_out_valid & fifo_out_ready;

  eei_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (req.data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  eei_mem #(
    .W     (8),
    .DEPTH (eei_pkg::PAGE_BYTES),
    .AW    (eei_pkg::OFF_W)
  ) u_page (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (load),
    .waddr_i (ptr[eei_pkg::OFF_W-1:0]),
    .wdata_i (fifo_out_data),
    .re_i    (cst == eei_pkg::CS_COPY),
    .raddr_i (copy_idx[eei_pkg::OFF_W-1:0]),
    .rdata_o (pb_rdata)
  );

  eei_mem #(
    .W     (8),
    .DEPTH (eei_pkg::MEM_BYTES),
    .AW    (eei_pkg::PTR_W)
  ) u_array (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (copy_we),
    .waddr_i ({ptr[eei_pkg::PTR_W-1:eei_pkg::OFF_W], copy_off}),
    .wdata_i (pb_rdata),
    .re_i    (arr_re),
    .raddr_i (ptr),
    .rdata_o (arr_rdata)
  );

  assign arr_re = req_new && req.cmd == eei_pkg::CMD_READ && !fifo_out_valid;

  // ************************************************************
  // Core state machine
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cst       <= eei_pkg::CS_IDLE;
      ptr       <= '0;
      marks     <= '0;
      copy_idx  <= 7'h00;
      copy_we   <= 1'b0;
      copy_off  <= '0;
      timer     <= '0;
      resp_data <= 8'h00;
      ack_tog   <= 1'b0;
    end else begin
      copy_we <= 1'b0;
      if (load) begin
        marks[ptr[eei_pkg::OFF_W-1:0]] <= 1'b1;
        ptr[eei_pkg::OFF_W-1:0] <= ptr[eei_pkg::OFF_W-1:0] + 6'h01;
      end
      case (cst)
        eei_pkg::CS_IDLE: begin
          if (req_new) begin
            case (req.cmd)
              eei_pkg::CMD_SET_ADDR: begin
                if (!fifo_out_valid) begin
                  ptr     <= req.addr[eei_pkg::PTR_W-1:0];
                  ack_tog <= ~ack_tog;
                end
              end
              eei_pkg::CMD_WRITE: begin
                if (fifo_in_ready) begin
                  ack_tog <= ~ack_tog;
                end
              end
              eei_pkg::CMD_STOP: begin
                if (!fifo_out_valid) begin
                  ack_tog <= ~ack_tog;
                  if (marks != '0 && !wp_s) begin
                    cst      <= eei_pkg::CS_COPY;
                    copy_idx <= 7'h00;
                  end else begin
                    marks <= '0;
                  end
                end
              end
              default: begin
                if (!fifo_out_valid) begin
                  cst <= eei_pkg::CS_READ;
                end
              end
            endcase
          end
        end
        eei_pkg::CS_READ: begin
          resp_data <= arr_rdata;
          ptr       <= ptr + 15'h0001;
          ack_tog   <= ~ack_tog;
          cst       <= eei_pkg::CS_IDLE;
        end
        eei_pkg::CS_COPY: begin
          if (copy_idx == eei_pkg::COPY_END) begin
            marks <= '0;
            timer <= 20'(WRITE_CYCLES - 1);
            cst   <= eei_pkg::CS_HOLD;
          end else begin
            copy_we  <= marks[copy_idx[eei_pkg::OFF_W-1:0]];
            copy_off <= copy_idx[eei_pkg::OFF_W-1:0];
            copy_idx <= copy_idx + 7'h01;
          end
        end
        eei_pkg::CS_HOLD: begin
          if (timer == '0) begin
            cst <= eei_pkg::CS_IDLE;
          end else begin
            timer <= timer - 20'h00001;
          end
        end
        default: begin
          cst <= eei_pkg::CS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/eei_target_asserts.sv ***
// Port checker for the serial EEPROM target
`timescale 1ns/1ps
`default_nettype none
module eei_target_asserts #(
  parameter int WRITE_CYCLES    = 200,
  parameter int POWER_UP_CYCLES = 50
) (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       link_clk_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       wp_i,
  input wire logic [2:0] strap_address_pins_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  input wire logic       ready_o
);
  // ****************************************
  // Cycle counters
  // ****************************************
  logic [19:0] up_cnt;
  logic [19:0] low_cnt;
  logic        seen;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      up_cnt <= '0;
    end else if (up_cnt != '1) begin
      up_cnt <= up_cnt + 20'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || ready_o) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 20'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    seen <= rst_n_i && (seen || ready_o);
  end
  // ****************************************
  // Assertions
  // ****************************************
  chk_ready_early: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ready_o |-> up_cnt >= 20'(POWER_UP_CYCLES)) else $error("ready before power-up delay");
  chk_ready_due: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    up_cnt == 20'(POWER_UP_CYCLES + 8) |-> seen || ready_o) else $error("ready late after power-up");
  chk_busy_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seen && !ready_o |-> low_cnt < 20'(WRITE_CYCLES + 200)) else $error("write cycle too long");
  chk_busy_min: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seen && $rose(ready_o) |-> $past(low_cnt) >= 20'(WRITE_CYCLES)) else $error("write cycle too short");
  chk_wp_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seen && $fell(ready_o) |-> !wp_i && !$past(wp_i, 40)) else $error("write cycle while protected");
  chk_busy_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!ready_o)[*8] |-> sda_oe_n_o) else $error("data line driven while busy");
  chk_low_only: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    sda_o == 1'h0) else $error("data pin driven high");
  chk_drive_edge: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $changed(sda_oe_n_o) |-> !scl_i) else $error("data changed while clock high");
  chk_pin_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    !sda_oe_n_o |-> !sda_i) else $error("data line not low while driven");
endmodule
bind eei_target eei_target_asserts #(.WRITE_CYCLES(WRITE_CYCLES), .POWER_UP_CYCLES(POWER_UP_CYCLES)) i_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
  .wp_i(wp_i), .strap_address_pins_i(strap_address_pins_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .ready_o(ready_o));
`default_nettype wire

// *** testbench/eei_ctrl_model.sv ***
// Bus controller model driving clock and data
`timescale 1ns/1ps
`default_nettype none
module eei_ctrl_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  // Quarter bit time, 2.6 us period
  localparam time Q = 650;
  logic glitch;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
    glitch = 1'h0;
  end
  task automatic bus_start();
    sda_o = 1'h1;
    #Q;
    scl_o = 1'h1;
    #Q;
    sda_o = 1'h0;
    #Q;
    scl_o = 1'h0;
    #Q;
  endtask
  task automatic bus_stop();
    sda_o = 1'h0;
    #Q;
    scl_o = 1'h1;
    #Q;
    sda_o = 1'h1;
    #(2 * Q);
  endtask
  // Nine bits, data changed only while clock low
  task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_o = tx[i];
      #(Q / 2);
      scl_o = glitch;
      #50;
      scl_o = 1'h0;
      #(Q / 2 - 50);
      scl_o = 1'h1;
      #Q;
      rx[i] = sda_i;
      #Q;
      scl_o = 1'h0;
      #Q;
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the serial EEPROM target
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // Setup
  // ****************************************
  localparam int WR_CYC = 3000;
  localparam int PU_CYC = 3000;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] AW = {eei_pkg::DEV_TYPE_CODE, STRAP, 1'h0};
  logic       core_clk;
  logic       link_clk;
  logic       rst_n;
  logic       wp;
  logic       scl;
  logic       ctl_sda;
  logic       dut_sda;
  logic       sda_oe_n;
  logic       ready;
  logic [8:0] rx;
  int         n;
  int         fails;
  int         num_checks;
  wire logic  sda = ctl_sda & (sda_oe_n | dut_sda);
  initial begin
    core_clk = 1'h0;
    link_clk = 1'h0;
    rst_n = 1'h0;
    wp = 1'h0;
    fails = 0;
    num_checks = 0;
  end
  always #5 core_clk = ~core_clk;
  always #6 link_clk = ~link_clk;
  eei_target #(.WRITE_CYCLES(WR_CYC), .POWER_UP_CYCLES(PU_CYC), .FIFO_DEPTH(16)) i_eei_target (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
    .wp_i(wp), .strap_address_pins_i(STRAP), .sda_o(dut_sda), .sda_oe_n_o(sda_oe_n), .ready_o(ready));
  eei_ctrl_model i_eei_ctrl_model (.scl_o(scl), .sda_o(ctl_sda), .sda_i(sda));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic nak);
    i_eei_ctrl_model.xbyte({b, 1'h1}, rx);
    cmp_bit(rx[0], nak, "acknowledge");
  endtask
  task automatic hdr(input logic [15:0] a);
    i_eei_ctrl_model.bus_start();
    wr(AW, 1'h0);
    wr(a[15:8], 1'h0);
    wr(a[7:0], 1'h0);
  endtask
  task automatic sel_rd(input logic [15:0] a, input int cnt, input logic [15:0] exp);
    hdr(a);
    i_eei_ctrl_model.bus_start();
    wr({AW[7:1], 1'h1}, 1'h0);
    for (int i = 0; i < cnt; i++) begin
      i_eei_ctrl_model.xbyte({8'hFF, i == cnt - 1}, rx);
      cmp_byte(rx[8:1], exp[15 - 8 * i -: 8], "read data");
    end
    i_eei_ctrl_model.bus_stop();
  endtask
  task automatic wait_ready(input int lim);
    n = 0;
    while (ready !== 1'h1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_up();
    cmp_bit(ready, 1'h0, "ready after reset");
    i_eei_ctrl_model.bus_start();
    wr(AW, 1'h1);
    i_eei_ctrl_model.bus_stop();
    wait_ready(PU_CYC + 100);
    cmp_bit(ready, 1'h1, "ready after power-up");
    $display("t_power_up done");
  endtask
  task automatic t_page_wrap();
    hdr(16'h817E);
    wr(8'hA1, 1'h0);
    wr(8'hB2, 1'h0);
    wr(8'hC3, 1'h0);
    i_eei_ctrl_model.bus_stop();
    repeat (20) @(negedge core_clk);
    cmp_bit(ready, 1'h0, "busy after stop");
    i_eei_ctrl_model.bus_start();
    wr(AW, 1'h1);
    i_eei_ctrl_model.bus_stop();
    wait_ready(WR_CYC + 400);
    cmp_bit(ready, 1'h1, "ready after write");
    sel_rd(16'h017E, 2, 16'hA1B2);
    sel_rd(16'h0140, 1, 16'hC300);
    $display("t_page_wrap done");
  endtask
  task automatic t_protect();
    @(negedge core_clk);
    wp = 1'h1;
    hdr(16'h017E);
    wr(8'h55, 1'h0);
    i_eei_ctrl_model.bus_stop();
    repeat (200) @(negedge core_clk);
    cmp_bit(ready, 1'h1, "no write cycle");
    sel_rd(16'h017E, 1, 16'hA100);
    @(negedge core_clk);
    wp = 1'h0;
    $display("t_protect done");
  endtask
  task automatic t_addr_miss();
    i_eei_ctrl_model.bus_start();
    wr({eei_pkg::DEV_TYPE_CODE, STRAP ^ 3'h2, 1'h0}, 1'h1);
    i_eei_ctrl_model.bus_stop();
    i_eei_ctrl_model.bus_start();
    wr({~eei_pkg::DEV_TYPE_CODE, STRAP, 1'h1}, 1'h1);
    i_eei_ctrl_model.bus_stop();
    i_eei_ctrl_model.glitch = 1'h1;
    i_eei_ctrl_model.bus_start();
    wr(AW, 1'h0);
    i_eei_ctrl_model.glitch = 1'h0;
    i_eei_ctrl_model.bus_stop();
    $display("t_addr_miss done");
  endtask
  // ****************************************
  // Run control
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'h1;
    t_power_up();
    t_page_wrap();
    t_protect();
    t_addr_miss();
    end_of_test();
  end
  initial begin
    #980us;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
